// File: rtl/rx_chan_pkg.sv
// Constants, register map and shared types for the receive channel.
// Assumes a single 200 MHz system clock and an Avalon-MM register master.
// What this block does
// [RL1] After a falling edge wait half a bit before rechecking the line.
// [RL2] Line high at recheck rejects the start bit and hunting resumes.
// [RL3] Sample each bit at its centre, LSB first, done after half stop bit.
// [RL4] Unused upper data bits of a short character are stored as zero.
// [RL5] Queue holds three; ready while any present, full while all three.
// [RL6] A data read returns the oldest entry and pops it with its status.
// [RL7] Break, framing and parity stored per character; overrun and break change apart.
// [RL8] Error bits are written with the character before ready rises.
// [RL9] Line low for a whole character stores zero, marks break, sets break change.
// [RL10] Break ends after the line is high for two crystal clock edges.
// [RL11] Break change sets at break start and end; only error reset or receiver reset clears it.
// [RL12] Non-zero character with a low stop sample is a framing error.
// [RL13] Line still low a whole bit after a low stop acts as a new start.
// [RL14] Parity error when computed parity differs from the received bit.
// [RL15] Per-character status leaves with the character when it is popped.
// [RL16] Overrun when queue and shifter full and a start arrives; newest overwrites. Flag sets six 16X ticks after the start recheck, if both still full.
// [RL17] Overrun holds until error reset; queue stays valid; loading resumes.
// [RL18] In normal mode a disabled receiver raises no interrupt.
// [RL19] Character mode shows head status; block mode ORs heads since error reset.
// [RL20] Reading status never pops the queue.
// [RL21] With flow control, request to send drops on start while full, returns on space.
// [RL22] In normal mode a disabled receiver can be drained but accepts no new characters.
// [RL23] Receiver reset clears queue, status, pins and interrupt; stays disabled.
// [RL24] The serial input is synchronised before edge detection or sampling.
package rx_chan_pkg;
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_CMD = 4'h3;
  localparam logic [3:0] ADDR_INT = 4'h4;
  localparam logic [3:0] ADDR_DIV = 4'h5;
  // Command codes written to ADDR_CMD
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_ENABLE = 3'h1;
  localparam logic [2:0] CMD_DISABLE = 3'h2;
  localparam logic [2:0] CMD_RX_RESET = 3'h3;
  localparam logic [2:0] CMD_ERR_RESET = 3'h4;
  localparam logic [2:0] CMD_BRK_RESET = 3'h5;
  localparam int DEPTH = 3;
  localparam logic [15:0] DIV_RESET = 16'h0006;
  localparam logic [4:0] OVR_GRACE_TICKS = 5'h06;
  localparam logic [4:0] HALF_TICKS = 5'h08;
  localparam logic [4:0] FULL_TICKS = 5'h10;
  localparam logic [1:0] BRK_END_EDGES = 2'h2;
  // Control register layout
  typedef struct packed {
    logic fc_en;
    logic block_mode;
    logic multidrop;
    logic x1_mode;
    logic par_odd;
    logic par_en;
    logic [1:0] len_sel;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = '{default: 1'b0, len_sel: 2'h3};
  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } entry_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_BITS = 3'b010,
    ST_STOP = 3'b011,
    ST_BREAK = 3'b100
  } rx_state_t;
endpackage : rx_chan_pkg

// File: rtl/rx_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/100ps
module rx_sync3 (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic async_in,
  output logic level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level_q <= 1'b1;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q; // see [RL24]
      end
    end
  end
endmodule : rx_sync3

// File: rtl/rx_channel.sv
// Receive path of one asynchronous serial channel with a three-deep queue.
// Assumes an Avalon-MM master on clk_sys, a 16X tick divided from clk_sys and a 1X bit clock from a pin.
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
module rx_channel
  import rx_chan_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic serial_in,
  input wire logic bit_clock_in,
  input wire logic crystal_clock,
  output logic request_to_send_out_n,
  output logic receive_ready_flag,
  output logic fifo_full_flag,
  output logic interrupt_out_n
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic line;
  logic bclk;
  logic xclk;
  rx_sync3 u_sync_line (.clk_sys(clk_sys), .resetn(resetn), .async_in(serial_in),
    .level_q(line));
  rx_sync3 u_sync_bclk (.clk_sys(clk_sys), .resetn(resetn), .async_in(bit_clock_in),
    .level_q(bclk));
  rx_sync3 u_sync_xclk (.clk_sys(clk_sys), .resetn(resetn), .async_in(crystal_clock),
    .level_q(xclk));
  logic bclk_prev_q;
  logic xclk_prev_q;
  logic line_prev_q;
  wire bclk_rise = bclk & ~bclk_prev_q;
  wire xclk_edge = xclk ^ xclk_prev_q;
  wire line_fall = line_prev_q & ~line;

  // ****************************************
  // Registers
  // ****************************************
  ctrl_t ctrl_q;
  logic en_q;
  logic [15:0] div_q;
  logic [1:0] int_sel_q;
  logic ovr_q;
  logic cob_q;
  logic [2:0] blk_err_q;
  logic [7:0] rd_q;
  logic wait_q;
  entry_t mem_q [DEPTH];
  logic [1:0] rp_q;
  logic [1:0] wp_q;
  logic [1:0] cnt_q;
  wire acc = (avs_read | avs_write) & ~wait_q;
  wire wr = avs_write & acc;
  wire rd = avs_read & acc;
  wire sel_data = (avs_address == ADDR_DATA);
  wire sel_status = (avs_address == ADDR_STATUS);
  wire sel_ctrl = (avs_address == ADDR_CTRL);
  wire sel_cmd = (avs_address == ADDR_CMD);
  wire sel_int = (avs_address == ADDR_INT);
  wire sel_div = (avs_address == ADDR_DIV);
  wire [2:0] cmd = wr && sel_cmd ? avs_writedata[2:0] : CMD_NONE;
  wire rx_reset = (cmd == CMD_RX_RESET);
  wire err_reset = (cmd == CMD_ERR_RESET);
  wire q_empty = (cnt_q == 2'h0);
  wire q_full = (cnt_q == DEPTH[1:0]);
  wire pop = rd & sel_data & ~q_empty; // see [RL6] [RL20]
  entry_t head;
  assign head = mem_q[rp_q];

  // ****************************************
  // Bit timing
  // ****************************************
  rx_state_t st_q;
  logic [15:0] pre_q;
  logic [4:0] tick_q;
  logic [3:0] nbit_q;
  logic [8:0] sh_q;
  logic [4:0] grace_q;
  logic pend_q;
  logic brk_q;
  logic [1:0] hi_q;
  logic rts_block_q;
  entry_t pend_e_q;
  wire pre_done = (pre_q == 16'h0000);
  wire tick16 = pre_done;
  // One tick is one 16X period, or a whole bit in 1X mode
  wire tick = ctrl_q.x1_mode ? bclk_rise : tick16;
  wire [4:0] half_n = ctrl_q.x1_mode ? 5'h01 : HALF_TICKS;
  wire [4:0] full_n = ctrl_q.x1_mode ? 5'h01 : FULL_TICKS;
  wire tick_end = tick & (tick_q == 5'h01);
  wire [3:0] data_bits = {2'b00, ctrl_q.len_sel} + 4'h5;
  wire [3:0] total_bits = data_bits + {3'b000, ctrl_q.par_en};
  wire active = en_q | ctrl_q.multidrop;
  // Assemble finished character
  wire [7:0] dmask = 8'hFF >> (4'h8 - data_bits);
  wire [8:0] aligned = sh_q >> (4'h9 - total_bits);
  wire [7:0] dval = aligned[7:0] & dmask; // see [RL4]
  wire pbit = aligned[data_bits];
  wire par_bad = ctrl_q.par_en &
    ((^dval) ^ pbit ^ ctrl_q.par_odd); // see [RL14]
  wire all_zero = (dval == 8'h00) & ~(ctrl_q.par_en & pbit);
  wire stop_low = (st_q == ST_STOP) & tick_end & ~line;
  wire char_done = (st_q == ST_STOP) & tick_end;
  wire is_brk = all_zero & ~line; // see [RL9]
  entry_t new_e;
  assign new_e = '{brk: is_brk, fe: stop_low & ~all_zero, pe: par_bad & ~is_brk,
    data: dval}; // see [RL7] [RL12]
  wire load_now = char_done & ~q_full & ~pend_q;
  wire load_pend = pend_q & ~q_full;
  wire push = load_now | load_pend; // see [RL8] [RL17]

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bclk_prev_q <= 1'b1;
      xclk_prev_q <= 1'b1;
      line_prev_q <= 1'b1;
    end else begin
      bclk_prev_q <= bclk;
      xclk_prev_q <= xclk;
      line_prev_q <= line;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn || pre_done) begin
      pre_q <= div_q;
    end else begin
      pre_q <= pre_q - 16'h0001;
    end
  end

  // ****************************************
  // Receive state machine
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!resetn || rx_reset || !active) begin // see [RL22] [RL23]
      st_q <= ST_IDLE;
      tick_q <= 5'h00;
      nbit_q <= 4'h0;
      sh_q <= 9'h000;
      hi_q <= 2'h0;
      brk_q <= 1'b0;
    end else begin
      if (tick) begin
        tick_q <= tick_q - 5'h01;
      end
      case (st_q)
        ST_IDLE: begin
          if (line_fall) begin
            st_q <= ST_START;
            tick_q <= half_n; // see [RL1]
          end
        end
        ST_START: begin
          if (tick_end) begin
            if (line) begin
              st_q <= ST_IDLE; // see [RL2]
            end else begin
              st_q <= ST_BITS;
              tick_q <= full_n;
              nbit_q <= total_bits;
            end
          end
        end
        ST_BITS: begin
          if (tick_end) begin
            sh_q <= {line, sh_q[8:1]}; // see [RL3]
            tick_q <= full_n;
            nbit_q <= nbit_q - 4'h1;
            if (nbit_q == 4'h1) begin
              st_q <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (tick_end) begin
            if (is_brk) begin
              st_q <= ST_BREAK;
              brk_q <= 1'b1;
              hi_q <= 2'h0;
            end else if (!line) begin
              st_q <= ST_START; // see [RL13]
              tick_q <= full_n;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_BREAK: begin
          if (!line) begin
            hi_q <= 2'h0;
          end else if (xclk_edge) begin
            hi_q <= hi_q + 2'h1;
            if (hi_q + 2'h1 == BRK_END_EDGES) begin
              st_q <= ST_IDLE; // see [RL10]
              brk_q <= 1'b0;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Shift register holding and overrun
  // ****************************************
  wire start_ok = (st_q == ST_START) & tick_end & ~line;
  wire ovr_hit = pend_q & q_full & (grace_q == 5'h01) & tick16;
  always_ff @(posedge clk_sys) begin
    if (!resetn || rx_reset) begin
      pend_q <= 1'b0;
      pend_e_q <= '0;
      grace_q <= 5'h00;
    end else begin
      if (char_done && (q_full || pend_q) && !load_pend) begin
        pend_q <= 1'b1;
        pend_e_q <= new_e; // see [RL16]
      end else if (load_pend) begin
        pend_q <= 1'b0;
      end
      if (start_ok && pend_q && q_full) begin
        grace_q <= OVR_GRACE_TICKS;
      end else if (tick16 && grace_q != 5'h00) begin
        grace_q <= grace_q - 5'h01;
      end
    end
  end

  // ****************************************
  // Receive queue
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!resetn || rx_reset) begin
      rp_q <= 2'h0;
      wp_q <= 2'h0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= load_pend ? pend_e_q : new_e;
        wp_q <= (wp_q == DEPTH[1:0] - 2'h1) ? 2'h0 : wp_q + 2'h1;
      end
      if (pop) begin
        rp_q <= (rp_q == DEPTH[1:0] - 2'h1) ? 2'h0 : rp_q + 2'h1; // see [RL15]
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop}; // see [RL5]
    end
  end

  // ****************************************
  // Status, flow control and pins
  // ****************************************
  wire brk_start = (st_q == ST_STOP) & tick_end & is_brk;
  wire brk_end = (st_q == ST_BREAK) & line & xclk_edge & (hi_q + 2'h1 == BRK_END_EDGES);
  wire [2:0] head_err = q_empty ? 3'h0 : {head.brk, head.fe, head.pe};
  wire [2:0] shown_err = ctrl_q.block_mode ? (blk_err_q | head_err) : head_err; // see [RL19]
  wire irq_src = int_sel_q[0] ? q_full : ~q_empty;
  wire irq = active & ((int_sel_q[1] & irq_src) | cob_q); // see [RL18]
  always_ff @(posedge clk_sys) begin
    if (!resetn || rx_reset) begin
      ovr_q <= 1'b0;
      cob_q <= 1'b0;
      blk_err_q <= 3'h0;
      rts_block_q <= 1'b0;
      request_to_send_out_n <= 1'b0;
      receive_ready_flag <= 1'b0;
      fifo_full_flag <= 1'b0;
      interrupt_out_n <= 1'b1;
    end else begin
      if (ovr_hit) begin
        ovr_q <= 1'b1; // see [RL16]
      end else if (err_reset) begin
        ovr_q <= 1'b0; // see [RL17]
      end
      if (brk_start || brk_end) begin
        cob_q <= 1'b1; // see [RL9] [RL11]
      end else if (err_reset) begin
        cob_q <= 1'b0;
      end
      if (err_reset) begin
        blk_err_q <= 3'h0;
      end else if (pop) begin
        blk_err_q <= blk_err_q | head_err;
      end
      if (start_ok && q_full && ctrl_q.fc_en) begin
        rts_block_q <= 1'b1; // see [RL21]
      end else if (!q_full || !ctrl_q.fc_en) begin
        rts_block_q <= 1'b0;
      end
      request_to_send_out_n <= rts_block_q;
      receive_ready_flag <= ~q_empty;
      fifo_full_flag <= q_full;
      interrupt_out_n <= ~irq;
    end
  end

  // ****************************************
  // Avalon slave
  // ****************************************
  wire [31:0] status_word = {22'h00000, brk_q, cob_q, shown_err, ovr_q, en_q,
    pend_q, q_full, ~q_empty};
  wire [31:0] rd_mux = sel_data ? {24'h000000, head.data} :
    sel_status ? status_word :
    sel_ctrl ? {24'h000000, ctrl_q} :
    sel_int ? {30'h0000000, int_sel_q} :
    sel_div ? {16'h0000, div_q} : 32'h00000000;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wait_q <= 1'b0;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      ctrl_q <= CTRL_RESET;
      div_q <= DIV_RESET;
      int_sel_q <= 2'h0;
      en_q <= 1'b0;
    end else begin
      wait_q <= (avs_read | avs_write) & ~wait_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~wait_q);
      if (rd) begin
        avs_readdata <= rd_mux;
      end
      if (wr && sel_ctrl) begin
        ctrl_q <= ctrl_t'(avs_writedata[7:0]);
      end
      if (wr && sel_div) begin
        div_q <= avs_writedata[15:0];
      end
      if (wr && sel_int) begin
        int_sel_q <= avs_writedata[1:0];
      end
      if (cmd == CMD_ENABLE) begin
        en_q <= 1'b1;
      end else if (cmd == CMD_DISABLE || rx_reset) begin
        en_q <= 1'b0; // see [RL23]
      end
    end
  end
endmodule : rx_channel

// File: tb/rx_channel_asserts.sv
// Port checker for the receive channel.
// Assumes it is bound to rx_channel and sees only its ports.
`timescale 1ns/100ps
module rx_channel_asserts
  import rx_chan_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic request_to_send_out_n,
  input wire logic receive_ready_flag,
  input wire logic fifo_full_flag,
  input wire logic interrupt_out_n
);
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_req;
    avs_read || avs_write;
  endsequence
  sequence s_rd_stat;
    avs_read && !avs_waitrequest && avs_address == ADDR_STATUS;
  endsequence
  a_reset_outputs: assert property ($rose(resetn) |-> avs_waitrequest &&
    !receive_ready_flag && !fifo_full_flag && interrupt_out_n && !request_to_send_out_n)
    else $error("outputs wrong after reset");
  a_wait_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_has_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > ADDR_DIV
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_full_has_ready: assert property (fifo_full_flag |-> receive_ready_flag)
    else $error("full without ready");
  a_full_rise: assert property ($rose(fifo_full_flag) |-> $past(receive_ready_flag))
    else $error("full rose from empty");
  a_ready_fall: assert property ($fell(receive_ready_flag) |->
    $past(avs_read || avs_write) || $past(avs_read || avs_write, 2))
    else $error("ready fell without access");
  a_status_no_pop: assert property (s_rd_stat |=>
    $stable(receive_ready_flag) && $stable(fifo_full_flag)) else $error("status read popped");
  a_rts_rise: assert property ($rose(request_to_send_out_n) |-> fifo_full_flag)
    else $error("rts negated while not full");
  a_rts_return: assert property ($fell(fifo_full_flag) |-> ##[0:2]
    (!request_to_send_out_n || fifo_full_flag)) else $error("rts not reasserted");
endmodule : rx_channel_asserts

// File: tb/serial_tx_model.sv
// Far-end serial transmitter that drives the receive line.
// Assumes the divider reset value, so one bit lasts BIT_CYC clocks.
`timescale 1ns/100ps
module serial_tx_model #(
  parameter int BIT_CYC = 112
) (
  input wire logic clk_sys,
  output logic line_out
);
  // ********************
  // Line driver
  // ********************
  initial line_out = 1'b1;
  // Shifts n bits out LSB first, then returns to idle mark
  task automatic send(input logic [19:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      line_out <= bits[i];
      repeat (BIT_CYC - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    line_out <= 1'b1;
  endtask : send
endmodule : serial_tx_model

// File: tb/rx_channel_bench.sv
// Self-checking bench for the receive channel.
// Assumes the default divider: one bit is 112 clocks of clk_sys.
`timescale 1ns/100ps
module rx_channel_bench;
  import rx_chan_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic crystal_clock = 1'b0;
  logic bit_clock = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, serial_in, request_to_send_out_n;
  logic receive_ready_flag, fifo_full_flag, interrupt_out_n;
  int err_count = 0;
  int compares = 0;
  always #2.5 clk_sys = ~clk_sys;
  always #18.3 crystal_clock = ~crystal_clock;
  always #280 bit_clock = ~bit_clock;
  rx_channel rx_channel_inst (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .serial_in(serial_in),
    .bit_clock_in(bit_clock), .crystal_clock(crystal_clock),
    .request_to_send_out_n(request_to_send_out_n), .receive_ready_flag(receive_ready_flag),
    .fifo_full_flag(fifo_full_flag), .interrupt_out_n(interrupt_out_n));
  serial_tx_model serial_tx_model_inst (.clk_sys(clk_sys), .line_out(serial_in));
  // ********************
  // Tasks
  // ********************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] wd);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask : rd_chk
  task automatic cmd(input logic [2:0] c);
    bus(ADDR_CMD, 1'b1, {29'h0, c});
  endtask : cmd
  task automatic sendf(input logic [19:0] b, input int n);
    serial_tx_model_inst.send(b, n);
    repeat (20) @(posedge clk_sys);
  endtask : sendf
  task automatic send8(input logic [7:0] d);
    sendf({10'h0, 1'b1, d, 1'b0}, 10);
  endtask : send8
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // ********************
  // Tests
  // ********************
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    check({30'h0, interrupt_out_n, request_to_send_out_n}, 32'h2);
    rd_chk(ADDR_STATUS, 32'h000);
    rd_chk(4'hF, 32'h0);
    bus(ADDR_CTRL, 1'b1, 32'h83);
    bus(ADDR_INT, 1'b1, 32'h3);
    cmd(CMD_ENABLE);
    send8(8'hA5);
    rd_chk(ADDR_STATUS, 32'h009);
    rd_chk(ADDR_STATUS, 32'h009);
    rd_chk(ADDR_DATA, 32'hA5);
    rd_chk(ADDR_STATUS, 32'h008);
    // 1X mode: start edge lands mid-way between bit clock rises
    bus(ADDR_CTRL, 1'b1, 32'h93);
    @(posedge bit_clock);
    repeat (50) @(posedge clk_sys);
    send8(8'hC3);
    rd_chk(ADDR_DATA, 32'hC3);
    bus(ADDR_CTRL, 1'b1, 32'h83);
    send8(8'h11);
    send8(8'h22);
    send8(8'h33);
    rd_chk(ADDR_STATUS, 32'h00B);
    check({29'h0, receive_ready_flag, fifo_full_flag, interrupt_out_n}, 32'h6);
    send8(8'h44);
    check({31'h0, request_to_send_out_n}, 32'h1);
    rd_chk(ADDR_STATUS, 32'h00F);
    send8(8'h55);
    rd_chk(ADDR_STATUS, 32'h01F);
    rd_chk(ADDR_DATA, 32'h11);
    repeat (4) @(posedge clk_sys);
    check({31'h0, request_to_send_out_n}, 32'h0);
    rd_chk(ADDR_STATUS, 32'h01B);
    rd_chk(ADDR_DATA, 32'h22);
    rd_chk(ADDR_DATA, 32'h33);
    rd_chk(ADDR_DATA, 32'h55);
    rd_chk(ADDR_STATUS, 32'h018);
    cmd(CMD_ERR_RESET);
    rd_chk(ADDR_STATUS, 32'h008);
    bus(ADDR_CTRL, 1'b1, 32'h04);
    sendf({12'h0, 1'b1, 1'b0, 5'h13, 1'b0}, 8);
    sendf({12'h0, 1'b1, 1'b0, 5'h0C, 1'b0}, 8);
    rd_chk(ADDR_STATUS, 32'h029);
    rd_chk(ADDR_DATA, 32'h13);
    rd_chk(ADDR_STATUS, 32'h009);
    bus(ADDR_CTRL, 1'b1, 32'h44);
    rd_chk(ADDR_STATUS, 32'h029);
    rd_chk(ADDR_DATA, 32'h0C);
    bus(ADDR_CTRL, 1'b1, 32'h03);
    sendf({1'b1, 8'h33, 1'b0, 1'b0, 8'h0F, 1'b0}, 20);
    rd_chk(ADDR_STATUS, 32'h049);
    rd_chk(ADDR_DATA, 32'h0F);
    rd_chk(ADDR_DATA, 32'h33);
    fork
      serial_tx_model_inst.send(20'h0, 16);
      begin
        repeat (1344) @(posedge clk_sys);
        rd_chk(ADDR_STATUS, 32'h389);
        cmd(CMD_ERR_RESET);
        rd_chk(ADDR_STATUS, 32'h289);
      end
    join
    repeat (30) @(posedge clk_sys);
    rd_chk(ADDR_STATUS, 32'h189);
    cmd(CMD_ERR_RESET);
    bus(ADDR_INT, 1'b1, 32'h2);
    check({31'h0, interrupt_out_n}, 32'h0);
    cmd(CMD_DISABLE);
    repeat (2) @(posedge clk_sys);
    check({31'h0, interrupt_out_n}, 32'h1);
    send8(8'h5A);
    rd_chk(ADDR_STATUS, 32'h081);
    rd_chk(ADDR_DATA, 32'h00);
    rd_chk(ADDR_STATUS, 32'h000);
    cmd(CMD_ENABLE);
    send8(8'h77);
    cmd(CMD_RX_RESET);
    repeat (2) @(posedge clk_sys);
    rd_chk(ADDR_STATUS, 32'h000);
    send8(8'h66);
    rd_chk(ADDR_STATUS, 32'h000);
    finish_test();
  end
endmodule : rx_channel_bench
bind rx_channel rx_channel_asserts rx_channel_asserts_inst (.clk_sys(clk_sys),
  .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .request_to_send_out_n(request_to_send_out_n), .receive_ready_flag(receive_ready_flag),
  .fifo_full_flag(fifo_full_flag), .interrupt_out_n(interrupt_out_n));
